//--- rtl/bdmm_data_memory.sv
// Banked data memory of the CPU core with bank instructions, peripheral moves and an APB window.
`timescale 1ns/1ps
// Notes on behaviour
// - Bank select bits pick the bank only inside banked regions; elsewhere ignored.
// - Peripheral moves use P range 00h-1Fh and F range 00h-FFh, both directions.
// - Unused P range locations 18h-1Fh act as plain general purpose storage.
// - Indirect access through either file select reaches all memory with banking.
// - General purpose cells are 8 bits; RAM beyond 232 bytes is banked.
// - General purpose RAM is never cleared or set by any reset.
// - A load instruction sets the RAM bank field in one operation.
// - Peripheral registers are banked, core registers unbanked; a load sets peripheral bank.
// - Special function registers are static storage shared by CPU and peripherals.
// - Only 10h-17h are bank switched among special function locations.
module bdmm_data_memory #(
    parameter int PERIPH_BANKS = 4,
    parameter int GPR_BANKS = 2
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST_N,
    // Core data access.
    input wire logic [7:0] CORE_ADDR,
    input wire logic CORE_RD,
    input wire logic CORE_WR,
    input wire logic [7:0] CORE_WDATA,
    output logic [7:0] CORE_RDATA,
    output logic CORE_RVALID,
    // Peripheral moves.
    input wire logic MOVE_REQ,
    input wire logic MOVE_TO_PERIPH,
    input wire logic [4:0] MOVE_P,
    input wire logic [7:0] MOVE_F,
    output logic MOVE_DONE,
    // Bank instructions.
    input wire logic LOAD_PERIPH_BANK,
    input wire logic LOAD_RAM_BANK,
    input wire logic [3:0] BANK_LITERAL,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR
);
    localparam int PERIPH_BASE = bdmm_pkg::CORE_REGS;
    localparam int PGPR_BASE = PERIPH_BASE + PERIPH_BANKS * bdmm_pkg::PERIPH_WIN;
    localparam int GPR_BASE = PGPR_BASE + bdmm_pkg::PGPR_WIN;
    localparam int DEPTH = GPR_BASE + GPR_BANKS * bdmm_pkg::GPR_WIN;
    localparam int IDX_W = $clog2(DEPTH);

    logic [7:0] mem [DEPTH];
    logic [7:0] bank_reg;
    logic [7:0] bank_next;
    logic gpr_banked_reg;
    logic [7:0] last_addr_reg;
    bdmm_pkg::bdmm_region_t last_region_reg;
    logic [7:0] file_select_0;
    logic [7:0] file_select_1;
    logic [7:0] acc_addr;
    logic [7:0] acc_eff;
    logic [7:0] src_eff;
    logic [7:0] dst_eff;
    bdmm_pkg::bdmm_region_t acc_rg;
    bdmm_pkg::bdmm_region_t src_rg;
    bdmm_pkg::bdmm_region_t dst_rg;
    logic [IDX_W-1:0] acc_idx;
    logic [IDX_W-1:0] src_idx;
    logic [IDX_W-1:0] dst_idx;
    logic [7:0] acc_data;
    logic [7:0] src_data;
    logic wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [7:0] wr_data;
    logic bank_wr;
    logic apb_acc;
    logic apb_bank_hit;
    logic apb_wr;

    assign file_select_0 = mem[bdmm_pkg::ADR_FILE_SELECT0];
    assign file_select_1 = mem[bdmm_pkg::ADR_FILE_SELECT1];

    // Resolves an indirect data address to the file select value behind it.
    function automatic logic [7:0] eff_addr(input logic [7:0] a);
        if (a == bdmm_pkg::ADR_INDIRECT0) begin
            return file_select_0;
        end else if (a == bdmm_pkg::ADR_INDIRECT1) begin
            return file_select_1;
        end
        return a;
    endfunction

    // Classifies an effective address into its region under a bank select value.
    function automatic bdmm_pkg::bdmm_region_t region_of(input logic [7:0] a, input logic [7:0] sel);
        logic [3:0] pb;
        logic [3:0] gb;
        pb = sel[bdmm_pkg::PB_LSB +: bdmm_pkg::NIB_W];
        gb = gpr_banked_reg ? sel[bdmm_pkg::GB_LSB +: bdmm_pkg::NIB_W] : 4'h0;
        if (a == bdmm_pkg::ADR_INDIRECT0 || a == bdmm_pkg::ADR_INDIRECT1) begin
            return bdmm_pkg::BDMM_RG_NONE;
        end else if (a == bdmm_pkg::ADR_BANK_SELECT) begin
            return bdmm_pkg::BDMM_RG_BANKSEL;
        end else if (a < bdmm_pkg::ADR_PERIPH_LO) begin
            return bdmm_pkg::BDMM_RG_CORE;
        end else if (a < bdmm_pkg::ADR_PGPR_LO) begin
            return (32'(pb) < PERIPH_BANKS) ? bdmm_pkg::BDMM_RG_PERIPH : bdmm_pkg::BDMM_RG_NONE;
        end else if (a < bdmm_pkg::ADR_GPR_LO) begin
            return bdmm_pkg::BDMM_RG_PGPR;
        end
        return (32'(gb) < GPR_BANKS) ? bdmm_pkg::BDMM_RG_GPR : bdmm_pkg::BDMM_RG_NONE;
    endfunction

    // Maps an effective address to its storage cell; bank bits count only in banked regions.
    function automatic logic [IDX_W-1:0] index_of(input logic [7:0] a, input logic [7:0] sel);
        logic [3:0] pb;
        logic [3:0] gb;
        int idx;
        pb = sel[bdmm_pkg::PB_LSB +: bdmm_pkg::NIB_W];
        gb = gpr_banked_reg ? sel[bdmm_pkg::GB_LSB +: bdmm_pkg::NIB_W] : 4'h0;
        idx = 32'(a);
        if (a >= bdmm_pkg::ADR_GPR_LO) begin
            idx = GPR_BASE + 32'(gb) * bdmm_pkg::GPR_WIN + 32'(a - bdmm_pkg::ADR_GPR_LO);
        end else if (a >= bdmm_pkg::ADR_PGPR_LO) begin
            idx = PGPR_BASE + 32'(a - bdmm_pkg::ADR_PGPR_LO);
        end else if (a >= bdmm_pkg::ADR_PERIPH_LO) begin
            idx = PERIPH_BASE + 32'(pb) * bdmm_pkg::PERIPH_WIN + 32'(a - bdmm_pkg::ADR_PERIPH_LO);
        end
        if (idx >= DEPTH) begin
            idx = 0;
        end
        return IDX_W'(idx);
    endfunction

    // Reads one cell of the resolved map.
    function automatic logic [7:0] read_cell(input bdmm_pkg::bdmm_region_t rg, input logic [IDX_W-1:0] idx);
        if (rg == bdmm_pkg::BDMM_RG_BANKSEL) begin
            return bank_reg;
        end else if (rg == bdmm_pkg::BDMM_RG_NONE) begin
            return 8'h00;
        end
        return mem[idx];
    endfunction

    assign acc_addr = CORE_ADDR;
    // Resolves all data paths in one process, so file select, bank and cell changes are seen at once.
    always_comb begin
        acc_eff = eff_addr(acc_addr);
        acc_rg = region_of(acc_eff, bank_reg);
        acc_idx = index_of(acc_eff, bank_reg);
        acc_data = read_cell(acc_rg, acc_idx);
        src_eff = MOVE_TO_PERIPH ? eff_addr(MOVE_F) : eff_addr({3'h0, MOVE_P});
        dst_eff = MOVE_TO_PERIPH ? eff_addr({3'h0, MOVE_P}) : eff_addr(MOVE_F);
        src_rg = region_of(src_eff, bank_reg);
        src_idx = index_of(src_eff, bank_reg);
        src_data = read_cell(src_rg, src_idx);
        dst_rg = region_of(dst_eff, bank_reg);
        dst_idx = index_of(dst_eff, bank_reg);
    end

    // Selects the single data write of the cycle; a move outranks a plain core write.
    always_comb begin
        wr_en = 1'b0;
        bank_wr = 1'b0;
        wr_idx = acc_idx;
        wr_data = CORE_WDATA;
        if (MOVE_REQ) begin
            wr_idx = dst_idx;
            wr_data = src_data;
            wr_en = dst_rg != bdmm_pkg::BDMM_RG_NONE && dst_rg != bdmm_pkg::BDMM_RG_BANKSEL;
            bank_wr = dst_rg == bdmm_pkg::BDMM_RG_BANKSEL;
        end else if (CORE_WR) begin
            wr_en = acc_rg != bdmm_pkg::BDMM_RG_NONE && acc_rg != bdmm_pkg::BDMM_RG_BANKSEL;
            bank_wr = acc_rg == bdmm_pkg::BDMM_RG_BANKSEL;
        end
    end

    // Storage cells carry no reset, so their contents survive every reset.
    always_ff @(posedge CLK) begin
        if (wr_en) begin
            mem[wr_idx] <= wr_data;
        end
    end

    assign apb_acc = PSEL && PENABLE;
    assign apb_bank_hit = PADDR == bdmm_pkg::APB_BANK;
    assign apb_wr = apb_acc && PREADY && PWRITE;

    // Bank select next value: instruction loads win over data writes, data writes over APB.
    always_comb begin
        bank_next = bank_reg;
        if (apb_wr && apb_bank_hit) begin
            bank_next = PWDATA[7:0];
        end
        if (bank_wr) begin
            bank_next = wr_data;
        end
        if (LOAD_PERIPH_BANK) begin
            bank_next[bdmm_pkg::PB_LSB +: bdmm_pkg::NIB_W] = BANK_LITERAL;
        end
        if (LOAD_RAM_BANK) begin
            bank_next[bdmm_pkg::GB_LSB +: bdmm_pkg::NIB_W] = BANK_LITERAL;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            bank_reg <= bdmm_pkg::BANK_RESET;
        end else begin
            bank_reg <= bank_next;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            CORE_RDATA <= 8'h00;
            CORE_RVALID <= 1'b0;
            MOVE_DONE <= 1'b0;
        end else begin
            CORE_RVALID <= CORE_RD && !MOVE_REQ;
            MOVE_DONE <= MOVE_REQ;
            if (CORE_RD && !MOVE_REQ) begin
                CORE_RDATA <= acc_data;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            last_addr_reg <= 8'h00;
            last_region_reg <= bdmm_pkg::BDMM_RG_NONE;
        end else if (MOVE_REQ) begin
            last_addr_reg <= dst_eff;
            last_region_reg <= dst_rg;
        end else if (CORE_RD || CORE_WR) begin
            last_addr_reg <= acc_eff;
            last_region_reg <= acc_rg;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            gpr_banked_reg <= bdmm_pkg::CFG_GPR_BANKED_RESET;
        end else if (apb_wr && PADDR == bdmm_pkg::APB_CFG) begin
            gpr_banked_reg <= PWDATA[0];
        end
    end

    // APB stalls a bank write while the core itself changes the bank select register.
    assign PREADY = !(apb_bank_hit && PWRITE && (bank_wr || LOAD_PERIPH_BANK || LOAD_RAM_BANK));
    assign PSLVERR = apb_acc && PADDR != bdmm_pkg::APB_BANK && PADDR != bdmm_pkg::APB_STATUS
                     && PADDR != bdmm_pkg::APB_CFG;

    // Read data is taken in the setup phase, so a bank change in the access phase shows on the next read.
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            unique case (PADDR)
                bdmm_pkg::APB_BANK: PRDATA <= {24'h00_0000, bank_reg};
                bdmm_pkg::APB_STATUS: PRDATA <= {21'h00_0000, last_region_reg, last_addr_reg};
                bdmm_pkg::APB_CFG: PRDATA <= {31'h0000_0000, gpr_banked_reg};
                default: PRDATA <= 32'h0000_0000;
            endcase
        end else if (apb_acc && PREADY) begin
            PRDATA <= 32'h0000_0000;
        end
    end

    sequence s_core_write;
        CORE_WR && !MOVE_REQ && acc_rg == bdmm_pkg::BDMM_RG_PGPR;
    endsequence
    sequence s_read_back;
        CORE_RD && !MOVE_REQ && !CORE_WR && acc_eff == $past(acc_eff);
    endsequence

    AST_PERIPH_LOAD: assert property (@(posedge CLK) disable iff (!RST_N)
        LOAD_PERIPH_BANK |=> bank_reg[3:0] == $past(BANK_LITERAL))
        else $error("peripheral bank load lost");
    AST_RAM_LOAD: assert property (@(posedge CLK) disable iff (!RST_N)
        LOAD_RAM_BANK |=> bank_reg[7:4] == $past(BANK_LITERAL))
        else $error("ram bank load lost");
    AST_NIBBLE_KEEP: assert property (@(posedge CLK) disable iff (!RST_N)
        LOAD_PERIPH_BANK && !LOAD_RAM_BANK && !bank_wr |=> bank_reg[7:4] == $past(bank_reg[7:4]))
        else $error("ram bank nibble disturbed");
    AST_UNBANKED: assert property (@(posedge CLK) disable iff (!RST_N)
        (acc_eff < bdmm_pkg::ADR_PERIPH_LO || (acc_eff >= bdmm_pkg::ADR_PGPR_LO && acc_eff < bdmm_pkg::ADR_GPR_LO))
        |-> acc_idx == index_of(acc_eff, 8'h00))
        else $error("bank bits changed an unbanked cell");
    AST_BANKED_SPAN: assert property (@(posedge CLK) disable iff (!RST_N)
        acc_rg == bdmm_pkg::BDMM_RG_PERIPH |-> acc_eff >= bdmm_pkg::ADR_PERIPH_LO && acc_eff <= bdmm_pkg::ADR_PERIPH_HI)
        else $error("banked area outside 10h-17h");
    AST_INDIRECT: assert property (@(posedge CLK) disable iff (!RST_N)
        acc_addr == bdmm_pkg::ADR_INDIRECT1 |-> acc_eff == file_select_1)
        else $error("indirect access ignored file select 1");
    AST_READ_BACK: assert property (@(posedge CLK) disable iff (!RST_N)
        s_core_write ##1 s_read_back |=> CORE_RVALID && CORE_RDATA == $past(CORE_WDATA, 2))
        else $error("general purpose cell lost a write");
    AST_MOVE: assert property (@(posedge CLK) disable iff (!RST_N)
        MOVE_REQ && wr_en |=> MOVE_DONE && mem[$past(dst_idx)] == $past(src_data))
        else $error("move did not land");
    AST_FLAT_RAM: assert property (@(posedge CLK) disable iff (!RST_N)
        !gpr_banked_reg && acc_eff >= bdmm_pkg::ADR_GPR_LO |-> acc_idx == index_of(acc_eff, {4'h0, bank_reg[3:0]}))
        else $error("ram bank used while banking off");
endmodule // bdmm_data_memory

//--- rtl/bdmm_pkg.sv
// Package with the address map, field layout and bus offsets of the banked data memory.
package bdmm_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 8;
    localparam int NIB_W = 4;
    localparam int PB_LSB = 0;
    localparam int GB_LSB = 4;
    localparam int CORE_REGS = 16;
    localparam int PERIPH_WIN = 8;
    localparam int PGPR_WIN = 8;
    localparam int GPR_WIN = 224;
    localparam logic [7:0] ADR_INDIRECT0 = 8'h00;
    localparam logic [7:0] ADR_FILE_SELECT0 = 8'h01;
    localparam logic [7:0] ADR_PC_LOW = 8'h02;
    localparam logic [7:0] ADR_PC_HIGH_LATCH = 8'h03;
    localparam logic [7:0] ADR_ARITH_STATUS = 8'h04;
    localparam logic [7:0] ADR_TIMER0_CTRL = 8'h05;
    localparam logic [7:0] ADR_PROC_STATUS = 8'h06;
    localparam logic [7:0] ADR_INT_FLAGS = 8'h07;
    localparam logic [7:0] ADR_INDIRECT1 = 8'h08;
    localparam logic [7:0] ADR_FILE_SELECT1 = 8'h09;
    localparam logic [7:0] ADR_WORKING_ACC = 8'h0A;
    localparam logic [7:0] ADR_TIMER0_LOW = 8'h0B;
    localparam logic [7:0] ADR_TIMER0_HIGH = 8'h0C;
    localparam logic [7:0] ADR_BANK_SELECT = 8'h0F;
    localparam logic [7:0] ADR_PERIPH_LO = 8'h10;
    localparam logic [7:0] ADR_PERIPH_HI = 8'h17;
    localparam logic [7:0] ADR_PGPR_LO = 8'h18;
    localparam logic [7:0] ADR_GPR_LO = 8'h20;
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam logic [11:0] APB_BANK = 12'h000;
    localparam logic [11:0] APB_STATUS = 12'h004;
    localparam logic [11:0] APB_CFG = 12'h008;
    localparam logic CFG_GPR_BANKED_RESET = 1'b1;
    typedef enum logic [2:0] {
        BDMM_RG_CORE,
        BDMM_RG_BANKSEL,
        BDMM_RG_PERIPH,
        BDMM_RG_PGPR,
        BDMM_RG_GPR,
        BDMM_RG_NONE
    } bdmm_region_t;
endpackage

//--- testbench/bdmm_core_model.sv
// CPU core model that issues data accesses, peripheral moves and bank loads.
`timescale 1ns/1ps
module bdmm_core_model (
    // Clock.
    input wire logic clk,
    // Data access.
    output logic [7:0] addr,
    output logic rd,
    output logic wr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid,
    // Peripheral moves.
    output logic mreq,
    output logic mto_p,
    output logic [4:0] mp,
    output logic [7:0] mf,
    input wire logic mdone,
    // Bank loads.
    output logic ld_p,
    output logic ld_r,
    output logic [3:0] lit
);
    initial begin
        {addr, rd, wr, wdata, mreq, mto_p, mp, mf, ld_p, ld_r, lit} = '0;
    end
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic read(input logic [7:0] a, output logic [8:0] r);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        r = {rvalid, rdata};
    endtask
    task automatic write_read(input logic [7:0] a, input logic [7:0] d, output logic [8:0] r);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        r = {rvalid, rdata};
    endtask
    task automatic move(input logic to_p, input logic [4:0] p, input logic [7:0] f, output logic done);
        @(posedge clk);
        mreq <= 1'b1;
        mto_p <= to_p;
        mp <= p;
        mf <= f;
        @(posedge clk);
        mreq <= 1'b0;
        #1;
        done = mdone;
    endtask
    task automatic load(input logic p, input logic r, input logic [3:0] l);
        @(posedge clk);
        ld_p <= p;
        ld_r <= r;
        lit <= l;
        @(posedge clk);
        ld_p <= 1'b0;
        ld_r <= 1'b0;
    endtask
endmodule // bdmm_core_model

//--- testbench/tb.sv
// Self-checking testbench of the banked data memory.
`timescale 1ns/1ps
module tb;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rvalid, mreq, mto_p, mdone, ld_p, ld_r, rd, wr, e, d;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] addr, wdata, rdata, mf;
    logic [4:0] mp;
    logic [3:0] lit;
    logic [8:0] rr;
    int wt = 0;
    int failures = 0;
    int cmp_count = 0;
    bdmm_data_memory #(.PERIPH_BANKS(4), .GPR_BANKS(2)) bdmm_data_memory_inst (
        .CLK(clk), .RST_N(rst_n), .CORE_ADDR(addr), .CORE_RD(rd), .CORE_WR(wr), .CORE_WDATA(wdata),
        .CORE_RDATA(rdata), .CORE_RVALID(rvalid), .MOVE_REQ(mreq), .MOVE_TO_PERIPH(mto_p), .MOVE_P(mp),
        .MOVE_F(mf), .MOVE_DONE(mdone), .LOAD_PERIPH_BANK(ld_p), .LOAD_RAM_BANK(ld_r), .BANK_LITERAL(lit),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr));
    bdmm_core_model bdmm_core_model_inst (
        .clk(clk), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid), .mreq(mreq),
        .mto_p(mto_p), .mp(mp), .mf(mf), .mdone(mdone), .ld_p(ld_p), .ld_r(ld_r), .lit(lit));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic close_out;
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        wt = 0;
        do begin
            @(posedge clk);
            wt++;
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] x);
        logic [8:0] r;
        bdmm_core_model_inst.read(a, r);
        chk(n, {23'h0, 1'b1, x}, {23'h0, r});
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        close_out();
    end
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk("bank_select", 32'h0, q);
        apb(1'b0, 12'h008, 32'h0);
        chk("cfg", 32'h1, {31'h0, q[0]});
        bdmm_core_model_inst.write(8'h18, 8'h5A);
        rchk("p_gpr_18", 8'h18, 8'h5A);
        bdmm_core_model_inst.write(8'h1F, 8'hFF);
        rchk("p_gpr_1f", 8'h1F, 8'hFF);
        bdmm_core_model_inst.write_read(8'h1E, 8'hC3, rr);
        chk("wr_rd_1e", 32'h1C3, {23'h0, rr});
        bdmm_core_model_inst.load(1'b1, 1'b0, 4'h0);
        bdmm_core_model_inst.write(8'h10, 8'h11);
        bdmm_core_model_inst.load(1'b1, 1'b0, 4'h1);
        bdmm_core_model_inst.write(8'h10, 8'h22);
        bdmm_core_model_inst.write(8'h0A, 8'h33);
        bdmm_core_model_inst.load(1'b1, 1'b0, 4'h0);
        rchk("periph_b0", 8'h10, 8'h11);
        rchk("core_0a", 8'h0A, 8'h33);
        rchk("unbanked_18", 8'h18, 8'h5A);
        bdmm_core_model_inst.load(1'b0, 1'b1, 4'h0);
        bdmm_core_model_inst.write(8'h20, 8'h44);
        bdmm_core_model_inst.load(1'b0, 1'b1, 4'h1);
        bdmm_core_model_inst.write(8'h20, 8'h55);
        apb(1'b0, 12'h000, 32'h0);
        chk("bank_nibbles", 32'h10, q);
        bdmm_core_model_inst.load(1'b0, 1'b1, 4'h0);
        rchk("gpr_b0", 8'h20, 8'h44);
        bdmm_core_model_inst.load(1'b0, 1'b1, 4'h1);
        rchk("gpr_b1", 8'h20, 8'h55);
        bdmm_core_model_inst.write(8'h01, 8'h20);
        bdmm_core_model_inst.write(8'h00, 8'h66);
        rchk("ind0_b1", 8'h20, 8'h66);
        bdmm_core_model_inst.load(1'b0, 1'b1, 4'h0);
        rchk("ind0_b0", 8'h20, 8'h44);
        bdmm_core_model_inst.write(8'h09, 8'h10);
        bdmm_core_model_inst.load(1'b1, 1'b0, 4'h1);
        rchk("ind1_periph", 8'h08, 8'h22);
        bdmm_core_model_inst.move(1'b0, 5'h18, 8'h30, d);
        chk("move_done", 32'h1, {31'h0, d});
        rchk("move_p_to_f", 8'h30, 8'h5A);
        bdmm_core_model_inst.move(1'b1, 5'h19, 8'h20, d);
        rchk("move_f_to_p", 8'h19, 8'h44);
        apb(1'b1, 12'h000, 32'h21);
        apb(1'b0, 12'h000, 32'h0);
        chk("apb_bank", 32'h21, q);
        rchk("apb_bank_periph", 8'h10, 8'h22);
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, e});
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rchk("keep_18", 8'h18, 8'h5A);
        rchk("keep_30", 8'h30, 8'h5A);
        apb(1'b0, 12'h000, 32'h0);
        chk("bank_after_reset", 32'h0, q);
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk("cfg_off", 32'h0, {31'h0, q[0]});
        bdmm_core_model_inst.load(1'b0, 1'b1, 4'h1);
        rchk("flat_ram", 8'h20, 8'h44);
        apb(1'b0, 12'h004, 32'h0);
        chk("status", 32'h0000_0420, q);
        fork
            apb(1'b1, 12'h000, 32'h03);
            begin
                @(posedge clk);
                bdmm_core_model_inst.load(1'b1, 1'b0, 4'h2);
            end
        join
        chk("apb_stall", 32'h2, wt);
        apb(1'b0, 12'h000, 32'h0);
        chk("bank_after_stall", 32'h03, q);
        close_out();
    end
endmodule // tb
